// file: design/mode_sup_pkg.sv
// Package for the operating-mode supervisor: modes, wake and fault records, timing counts.
// Assumes a single 50 MHz clock domain and plain-port control from the host-side SPI decoder.
package mode_sup_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ           = 50_000_000;
	localparam int RESET_HOLD_US    = 1000;       // 1.0 ms
	localparam int NREQ_TIMEOUT_MS  = 150;        // 150 ms
	localparam int RESET_HOLD_CYC   = (CLK_HZ / 1_000_000) * RESET_HOLD_US;
	localparam int NREQ_TIMEOUT_CYC = (CLK_HZ / 1000) * NREQ_TIMEOUT_MS;
	localparam int WD_PERIOD_CYC    = NREQ_TIMEOUT_CYC;
	localparam int CYCLIC_PERIOD_CYC = (CLK_HZ / 1000) * 50;
	localparam int CYCLIC_ON_CYC    = (CLK_HZ / 1_000_000) * 100;
	localparam int CNT_W            = 24;

	// ----------------------------------------
	// Mode select code and one-hot mode encodings
	// ----------------------------------------
	localparam logic [1:0] MODE_SEL_NORMAL = 2'h0;

	typedef enum logic [4:0] {
		MODE_RESET  = 5'h01,
		MODE_NREQ   = 5'h02,
		MODE_NORMAL = 5'h04,
		MODE_STOP   = 5'h08,
		MODE_SLEEP  = 5'h10
	} mode_t;

	// Wake sources that are recorded (chip select and external reset are not)
	typedef struct packed {
		logic lin;
		logic forced;
		logic wakeTwo;
		logic wakeOne;
	} wake_src_t;

	// Interrupt-capable fault conditions, level inputs from the analog side
	typedef struct packed {
		logic lowSideThermal;
		logic highSideThermal;
		logic linFault;
		logic regPrewarn;
		logic supplyOver;
		logic supplyUnder;
	} fault_t;

	// Low-power configuration
	typedef struct packed {
		logic cyclicSense;
		logic forcedWake;
		logic wakeOneEn;
		logic wakeTwoEn;
	} lp_cfg_t;

endpackage : mode_sup_pkg

// file: design/operating_mode_supervisor.sv
// Operating-mode state machine with reset, interrupt, wake-up and watchdog handling.
// Assumes mode writes and status reads arrive as one-cycle strobes from an SPI decoder on clk.
`timescale 1ns/1ps

// Overview of operation
// [R1] After power-up hold reset low 1.0 ms, release, then enter Normal Request.
// [R2] Reset mode on regulator low, watchdog failure, Sleep wake-up or Normal Request timeout.
// [R3] Normal Request follows Reset or Stop wake-up; regulator on, reset high, LIN receive-only.
// [R4] Normal Request runs a 150 ms timer; without Normal command fall back to Reset.
// [R5] Host writes timing control, then mode control with zero mode select, within timeout.
// [R6] Watchdog pin grounded: Reset goes straight to Normal; open: stay in Normal Request.
// [R7] Sleep entered from Normal by one command; regulator off, only wake sources active.
// [R8] Cyclic sense in low power: oscillator runs, high side pulses, wake inputs sampled.
// [R9] Sleep wake-up passes through Reset, records source, battery-fail flag stays clear.
// [R10] Stop entered only by command; regulator limited; wakes from device or host sources.
// [R11] Stop wake-up enters Normal Request with interrupt, except chip-select edge or reset line.
// [R12] Missing watchdog trigger or trigger in closed window sends Normal to Reset.
// [R13] Switches follow SPI and PWM in Normal Request and Normal; off in Reset.
// [R14] No new interrupt until all pending wake sources read from interrupt source register.
// [R15] Interrupt line low when signalled, high again after SPI status read.
// [R16] Interrupts only in Normal, Normal Request, Stop, never with reset low; Stop wake only.
// [R17] Normal interrupt sources: supply under/over, prewarning, LIN, high and low side thermal.
// [R18] LIN thermal, stuck or short faults disable driver until gone and read; overcurrent flag only.
// [R19] Reset held low while condition lasts, then at least 1 ms more.
// [R20] Regulator below threshold resets; regulator overtemperature disables it and sets flag.
// [R21] External reset low past filter holds Reset state until release, no extra stretch.
// [R22] No status bit for chip-select wake or external reset.
// [R23] Host services watchdog by writing the mode select bits.
// [R24] Watchdog clear in first half of period rejected as overflow; second half accepted.
// [R25] Sleep and Stop mode select encodings are design parameters.
module operating_mode_supervisor #(
	parameter logic [1:0] MODE_SEL_SLEEP   = 2'h1, // [R25]
	parameter logic [1:0] MODE_SEL_STOP    = 2'h2,
	parameter int         RESET_HOLD       = mode_sup_pkg::RESET_HOLD_CYC,
	parameter int         NREQ_TIMEOUT     = mode_sup_pkg::NREQ_TIMEOUT_CYC,
	parameter int         WD_PERIOD        = mode_sup_pkg::WD_PERIOD_CYC,
	parameter int         CYCLIC_PERIOD    = mode_sup_pkg::CYCLIC_PERIOD_CYC,
	parameter int         CYCLIC_ON        = mode_sup_pkg::CYCLIC_ON_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 modeWrite,
	input  wire logic [1:0]           modeSelectBits,
	input  wire logic                 statusRead,
	input  wire logic                 linStatusRead,
	input  wire logic [5:0]           interruptMaskReg,
	input  wire mode_sup_pkg::lp_cfg_t lpCfg,
	input  wire logic                 hsCtrl,
	input  wire logic [1:0]           lsCtrl,
	input  wire logic                 pwmEnable,
	input  wire logic                 directPwmInput,
	input  wire logic                 watchdogConfigPin,
	input  wire logic                 regulatorBelowThreshold,
	input  wire logic                 regulatorOvertemp,
	input  wire mode_sup_pkg::fault_t faultIn,
	input  wire logic                 linOvertemp,
	input  wire logic                 linTxStuck,
	input  wire logic                 linRxShort,
	input  wire logic                 linOvercurrent,
	input  wire logic                 wakeInputOne,
	input  wire logic                 wakeInputTwo,
	input  wire logic                 linWake,
	input  wire logic                 chipSelectB,
	input  wire logic                 resetIn,
	output logic                      resetOut,
	output logic                      resetOe,
	output logic                      irqB,
	output mode_sup_pkg::mode_t       mode,
	output logic                      regulatorOn,
	output logic                      regulatorLimited,
	output logic                      regulatorOvertempFlag,
	output logic                      linRxOnly,
	output logic                      linDriverEn,
	output logic                      linOvercurrentFlag,
	output logic                      lowPowerOscOn,
	output logic                      highSideSwitch,
	output logic [1:0]                lowSideSwitches,
	output mode_sup_pkg::wake_src_t   interruptSourceReg,
	output mode_sup_pkg::fault_t      faultStatus,
	output logic                      batteryFailFlag,
	output logic                      watchdogOff
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] rstSync, csSync, w1Sync, w2Sync, pwmSync, oeSync;
	logic       extReset, csRise, lvl1, lvl2, lvl1Prev, lvl2Prev;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync <= 3'h7;
			csSync  <= 3'h7;
			w1Sync  <= 3'h0;
			w2Sync  <= 3'h0;
			pwmSync <= 3'h0;
			oeSync  <= 3'h7;
		end else begin
			rstSync <= {rstSync[1:0], resetIn};
			csSync  <= {csSync[1:0], chipSelectB};
			w1Sync  <= {w1Sync[1:0], wakeInputOne};
			w2Sync  <= {w2Sync[1:0], wakeInputTwo};
			pwmSync <= {pwmSync[1:0], directPwmInput};
			oeSync  <= {oeSync[1:0], resetOe};
		end
	end
	// Two-stage agreement filters glitches; own drive is delayed alongside so settling is not external
	assign extReset = !rstSync[1] && !rstSync[2] && oeSync == 3'h0 && !resetOe; // [R21]
	assign csRise   = csSync[1] && !csSync[2];
	assign lvl1     = w1Sync[2];
	assign lvl2     = w2Sync[2];

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	mode_sup_pkg::mode_t next_mode;
	logic [mode_sup_pkg::CNT_W-1:0] cnt, next_cnt, wdCnt, next_wdCnt, cyc, next_cyc;
	logic wdGround, next_wdGround, battery_fail_flag, next_battery_fail_flag, extSeen, next_extSeen;
	logic resetCond, wdFail, normalCmd, wakeHit, sampleNow, senseOn;
	mode_sup_pkg::wake_src_t wakeNow;

	function automatic logic expired(input logic [mode_sup_pkg::CNT_W-1:0] c, input int lim);
		expired = c >= lim[mode_sup_pkg::CNT_W-1:0] - 1'b1;
	endfunction : expired

	assign normalCmd = modeWrite && modeSelectBits == mode_sup_pkg::MODE_SEL_NORMAL;
	// Clear in first half or no clear by period end both fail
	assign wdFail = !wdGround && ((normalCmd && wdCnt < WD_PERIOD[mode_sup_pkg::CNT_W-1:0] / 2) // [R24]
		|| expired(wdCnt, WD_PERIOD)); // [R12]
	assign resetCond = regulatorBelowThreshold || extReset; // [R20]
	assign senseOn   = expired(cyc, CYCLIC_PERIOD) || cyc < CYCLIC_ON[mode_sup_pkg::CNT_W-1:0];
	assign sampleNow = lpCfg.cyclicSense && expired(cyc, CYCLIC_PERIOD);
	always_comb begin
		wakeNow.wakeOne = lpCfg.wakeOneEn && (lpCfg.cyclicSense ? sampleNow : 1'b1) && lvl1 != lvl1Prev;
		wakeNow.wakeTwo = lpCfg.wakeTwoEn && (lpCfg.cyclicSense ? sampleNow : 1'b1) && lvl2 != lvl2Prev;
		wakeNow.forced  = lpCfg.forcedWake && !lpCfg.cyclicSense && expired(cyc, CYCLIC_PERIOD);
		wakeNow.lin     = linWake;
	end
	assign wakeHit = |wakeNow;

	always_comb begin
		next_mode     = mode;
		next_cnt      = cnt + 1'b1;
		next_wdCnt    = wdCnt + 1'b1;
		next_cyc      = expired(cyc, CYCLIC_PERIOD) ? '0 : cyc + 1'b1;
		next_wdGround = wdGround;
		next_battery_fail_flag  = battery_fail_flag;
		next_extSeen  = extSeen;
		unique case (mode)
			mode_sup_pkg::MODE_RESET: begin
				next_wdGround = !watchdogConfigPin;
				if (resetCond) begin
					next_cnt     = '0; // [R19]
					next_extSeen = extReset && !regulatorBelowThreshold;
				end else if (expired(cnt, RESET_HOLD) || extSeen) begin // [R21]
					next_cnt     = '0; // [R1]
					next_extSeen = 1'b0;
					next_mode = !watchdogConfigPin ? mode_sup_pkg::MODE_NORMAL : mode_sup_pkg::MODE_NREQ; // [R6]
				end
			end
			mode_sup_pkg::MODE_NREQ: begin
				next_wdCnt = '0;
				if (resetCond) begin
					next_mode = mode_sup_pkg::MODE_RESET; next_cnt = '0;
				end else if (normalCmd) begin
					next_mode = mode_sup_pkg::MODE_NORMAL; // [R3]
				end else if (expired(cnt, NREQ_TIMEOUT)) begin
					next_mode = mode_sup_pkg::MODE_RESET; next_cnt = '0; // [R4]
				end
			end
			mode_sup_pkg::MODE_NORMAL: begin
				next_cyc = '0;
				if (resetCond || wdFail) begin
					next_mode = mode_sup_pkg::MODE_RESET; next_cnt = '0; // [R2]
				end else if (modeWrite && modeSelectBits == MODE_SEL_SLEEP) begin
					next_mode = mode_sup_pkg::MODE_SLEEP; // [R7]
				end else if (modeWrite && modeSelectBits == MODE_SEL_STOP) begin
					next_mode = mode_sup_pkg::MODE_STOP; // [R10]
				end else if (normalCmd) begin
					next_wdCnt = '0; // [R23]
				end
			end
			mode_sup_pkg::MODE_STOP: begin
				next_wdCnt = '0;
				next_cnt   = '0;
				if (regulatorBelowThreshold) begin
					next_mode = mode_sup_pkg::MODE_RESET;
				end else if (extReset) begin
					next_mode = mode_sup_pkg::MODE_RESET; // [R21]
				end else if (wakeHit || csRise) begin
					next_mode = mode_sup_pkg::MODE_NREQ; // [R11]
				end
			end
			mode_sup_pkg::MODE_SLEEP: begin
				next_cnt = '0;
				if (wakeHit) begin
					next_mode    = mode_sup_pkg::MODE_RESET; // [R9]
					next_battery_fail_flag = 1'b0;
				end
			end
			default: begin
				next_mode = mode_sup_pkg::MODE_RESET;
			end
		endcase
		// Outside Reset, note whether a coming Reset is held by the host alone
		if (mode != mode_sup_pkg::MODE_RESET) next_extSeen = extReset && !regulatorBelowThreshold;
		if (statusRead) next_battery_fail_flag = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode     <= mode_sup_pkg::MODE_RESET;
			cnt      <= '0;
			wdCnt    <= '0;
			cyc      <= '0;
			wdGround <= 1'b0;
			battery_fail_flag  <= 1'b1;
			extSeen  <= 1'b0;
			lvl1Prev <= 1'b0;
			lvl2Prev <= 1'b0;
		end else begin
			mode     <= next_mode;
			cnt      <= next_cnt;
			wdCnt    <= next_wdCnt;
			cyc      <= next_cyc;
			wdGround <= next_wdGround;
			battery_fail_flag  <= next_battery_fail_flag;
			extSeen  <= next_extSeen;
			lvl1Prev <= (!lpCfg.cyclicSense || sampleNow) ? lvl1 : lvl1Prev; // [R8]
			lvl2Prev <= (!lpCfg.cyclicSense || sampleNow) ? lvl2 : lvl2Prev;
		end
	end

	// ----------------------------------------
	// Interrupts and flags
	// ----------------------------------------
	mode_sup_pkg::wake_src_t next_src;
	mode_sup_pkg::fault_t    next_fault;
	logic next_irq, irqPend, next_irqPend, linLock, next_linLock, next_ovc, next_regOt;
	logic active;

	assign active = mode == mode_sup_pkg::MODE_NORMAL || mode == mode_sup_pkg::MODE_NREQ;
	always_comb begin
		next_src     = interruptSourceReg;
		next_fault   = faultStatus;
		next_irqPend = irqPend;
		next_linLock = linLock;
		next_ovc     = linOvercurrentFlag || linOvercurrent;
		next_regOt   = regulatorOvertempFlag || regulatorOvertemp; // [R20]
		if (statusRead) begin
			next_src     = '0;
			next_fault   = '0;
			next_irqPend = 1'b0; // [R15]
		end
		if (linStatusRead) begin
			next_ovc = linOvercurrent;
			if (!(linOvertemp || linTxStuck || linRxShort)) next_linLock = 1'b0; // [R18]
		end
		if (linOvertemp || linTxStuck || linRxShort) next_linLock = 1'b1;
		if (statusRead) next_regOt = regulatorOvertemp;
		// Sets win over the read clear
		if ((mode == mode_sup_pkg::MODE_STOP || mode == mode_sup_pkg::MODE_SLEEP) && wakeHit) begin
			next_src = interruptSourceReg | wakeNow; // [R22]
			if (mode == mode_sup_pkg::MODE_STOP) next_irqPend = 1'b1; // [R11]
		end
		if (active) begin
			next_fault = next_fault | faultIn; // [R17]
			if (|(faultIn & interruptMaskReg) && next_src == '0) next_irqPend = 1'b1; // [R14]
		end
		if (mode == mode_sup_pkg::MODE_RESET) next_irqPend = 1'b0;
		next_irq = next_irqPend && !resetOe && !extReset; // [R16]
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			interruptSourceReg    <= '0;
			faultStatus           <= '0;
			irqPend               <= 1'b0;
			irqB                  <= 1'b1;
			linLock               <= 1'b0;
			linOvercurrentFlag    <= 1'b0;
			regulatorOvertempFlag <= 1'b0;
		end else begin
			interruptSourceReg    <= next_src;
			faultStatus           <= next_fault;
			irqPend               <= next_irqPend;
			irqB                  <= !next_irq;
			linLock               <= next_linLock;
			linOvercurrentFlag    <= next_ovc;
			regulatorOvertempFlag <= next_regOt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic pwmGate;
	assign pwmGate          = !pwmEnable || pwmSync[2];
	assign resetOe          = mode == mode_sup_pkg::MODE_RESET && !extSeen; // [R19]
	assign resetOut         = 1'b0;
	assign regulatorOn      = mode != mode_sup_pkg::MODE_SLEEP && !regulatorOvertempFlag; // [R20]
	assign regulatorLimited = mode == mode_sup_pkg::MODE_STOP;
	assign linRxOnly        = mode != mode_sup_pkg::MODE_NORMAL;
	assign linDriverEn      = mode == mode_sup_pkg::MODE_NORMAL && !linLock;
	assign lowPowerOscOn    = (mode == mode_sup_pkg::MODE_STOP || mode == mode_sup_pkg::MODE_SLEEP)
		&& (lpCfg.cyclicSense || lpCfg.forcedWake);
	assign highSideSwitch   = active ? hsCtrl && pwmGate // [R13]
		: lowPowerOscOn && lpCfg.cyclicSense && senseOn; // [R8]
	assign lowSideSwitches  = active ? lsCtrl & {2{pwmGate}} : 2'h0;
	assign batteryFailFlag  = battery_fail_flag;
	assign watchdogOff      = wdGround;

	nreq_timeout_a: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
		mode == mode_sup_pkg::MODE_NREQ && !resetCond && !normalCmd && expired(cnt, NREQ_TIMEOUT)
		|=> mode == mode_sup_pkg::MODE_RESET) else $error("timeout did not reset");
	reset_switch_a: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
		mode == mode_sup_pkg::MODE_RESET |-> lowSideSwitches == 2'h0 && !highSideSwitch)
		else $error("switches on in reset");
	irq_reset_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
		mode == mode_sup_pkg::MODE_RESET ##1 mode == mode_sup_pkg::MODE_RESET |-> irqB)
		else $error("interrupt in reset");
	irq_ack_a: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
		statusRead && !wakeHit && !(active && |(faultIn & interruptMaskReg)) |=> irqB)
		else $error("irq not released");
	wd_early_a: assert property (@(posedge clk) disable iff (!rst_b) // [R24]
		mode == mode_sup_pkg::MODE_NORMAL && !wdGround && normalCmd
		&& wdCnt < WD_PERIOD[mode_sup_pkg::CNT_W-1:0] / 2 |=> mode == mode_sup_pkg::MODE_RESET)
		else $error("early clear accepted");
	sleep_wake_a: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
		mode == mode_sup_pkg::MODE_SLEEP && wakeHit |=> mode == mode_sup_pkg::MODE_RESET && !batteryFailFlag)
		else $error("sleep wake not reset");
	stop_cs_a: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
		mode == mode_sup_pkg::MODE_STOP && csRise && !wakeHit && !resetCond |=> $stable(irqPend))
		else $error("cs wake raised irq");
	wd_ground_a: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
		$past(mode) == mode_sup_pkg::MODE_RESET && mode != mode_sup_pkg::MODE_RESET && !watchdogConfigPin
		&& $past(watchdogConfigPin, 1) == 1'b0 |-> mode == mode_sup_pkg::MODE_NORMAL)
		else $error("grounded pin went via request");

endmodule : operating_mode_supervisor

// file: dv/host_mcu_model.sv
// Host microcontroller model: open-drain reset line and interrupt acknowledge by status read.
// Assumes the bench sets pullLow and ackDelay; an ackDelay of zero leaves interrupts unacknowledged.
`timescale 1ns/1ps
module host_mcu_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       resetOe,
	input  wire logic       irqB,
	input  wire logic       pullLow,
	input  wire logic [3:0] ackDelay,
	output logic            resetIn,
	output logic            statusRead
);
	// ----------------------------------------
	// Reset line and acknowledge
	// ----------------------------------------
	logic [3:0] waitCnt;
	logic       lineWas;

	// Weak pull-up, so the line is low while either party pulls it
	assign resetIn = !(resetOe || pullLow);

	// Slow hosts answer late; the delay lets the bench see the line stand low meanwhile
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			waitCnt    <= 4'h0;
			statusRead <= 1'b0;
			lineWas    <= 1'b0;
		end else begin
			statusRead <= 1'b0;
			waitCnt    <= 4'h0;
			lineWas    <= resetIn;
			if (ackDelay != 4'h0 && !irqB && !statusRead) begin
				waitCnt <= waitCnt + 4'h1;
				if (waitCnt == ackDelay) begin
					statusRead <= 1'b1;
				end
			end
			// Host coming out of reset reads the recorded wake source once
			if (resetIn && !lineWas) begin
				statusRead <= 1'b1;
			end
		end
	end
endmodule : host_mcu_model

// file: dv/operating_mode_supervisor_tb_top.sv
// Self-checking bench for the operating-mode supervisor against a mode reference model.
// Assumes shortened hold, timeout and watchdog counts; the host model owns reset line and status read.
`timescale 1ns/1ps
module operating_mode_supervisor_tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int         RH        = 20;
	localparam int         NT        = 200;
	localparam int         WP        = 100;
	localparam int         CP        = 50;
	localparam logic [1:0] SEL_SLEEP = 2'h1;
	localparam logic [1:0] SEL_STOP  = 2'h2;
	logic clk, rst_b, modeWrite, linStatusRead, hsCtrl, pwmEnable, directPwmInput, watchdogConfigPin, pullLow;
	logic regulatorBelowThreshold, regulatorOvertemp, linOvercurrent, wakeInputOne, wakeInputTwo, linWake, chipSelectB;
	logic statusRead, resetIn, resetOe, irqB, regulatorOn, regulatorLimited, regulatorOvertempFlag, linRxOnly;
	logic linDriverEn, linOvercurrentFlag, lowPowerOscOn, highSideSwitch, batteryFailFlag, watchdogOff;
	logic [1:0]                modeSelectBits, lsCtrl, lowSideSwitches;
	logic [2:0]                linErr;
	logic [3:0]                ackDelay;
	logic [5:0]                interruptMaskReg;
	logic [31:0]               seed = 32'h00000045;
	logic [31:0]               r;
	mode_sup_pkg::lp_cfg_t     lpCfg;
	mode_sup_pkg::fault_t      faultIn, faultStatus;
	mode_sup_pkg::mode_t       mode, expMode;
	mode_sup_pkg::wake_src_t   interruptSourceReg;
	int                        mismatches = 0;
	int                        compares = 0;
	int                        cycles = 0;
	int                        n, i;

	operating_mode_supervisor #(.MODE_SEL_SLEEP(SEL_SLEEP), .MODE_SEL_STOP(SEL_STOP), .RESET_HOLD(RH),
		.NREQ_TIMEOUT(NT), .WD_PERIOD(WP), .CYCLIC_PERIOD(CP), .CYCLIC_ON(5)) u_dut (
		.clk, .rst_b, .modeWrite, .modeSelectBits, .statusRead, .linStatusRead, .interruptMaskReg, .lpCfg,
		.hsCtrl, .lsCtrl, .pwmEnable, .directPwmInput, .watchdogConfigPin, .regulatorBelowThreshold,
		.regulatorOvertemp, .faultIn, .linOvertemp(linErr[2]), .linTxStuck(linErr[1]), .linRxShort(linErr[0]),
		.linOvercurrent, .wakeInputOne, .wakeInputTwo, .linWake, .chipSelectB, .resetIn, .resetOut(), .resetOe,
		.irqB, .mode, .regulatorOn, .regulatorLimited, .regulatorOvertempFlag, .linRxOnly, .linDriverEn,
		.linOvercurrentFlag, .lowPowerOscOn, .highSideSwitch, .lowSideSwitches, .interruptSourceReg,
		.faultStatus, .batteryFailFlag, .watchdogOff);

	host_mcu_model u_host (.clk, .rst_b, .resetOe, .irqB, .pullLow, .ackDelay, .resetIn, .statusRead);

	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Whole run is near 1,000 cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : tick

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Reference model: 0 hold over, 1 normal write, 2 stop, 3 sleep, 4 wake, other a reset cause
	task automatic step(input int e, input int lim);
		case (e)
			0: expMode = watchdogConfigPin ? mode_sup_pkg::MODE_NREQ : mode_sup_pkg::MODE_NORMAL;
			1: expMode = mode_sup_pkg::MODE_NORMAL;
			2: expMode = mode_sup_pkg::MODE_STOP;
			3: expMode = mode_sup_pkg::MODE_SLEEP;
			4: expMode = (expMode == mode_sup_pkg::MODE_SLEEP) ? mode_sup_pkg::MODE_RESET : mode_sup_pkg::MODE_NREQ;
			default: expMode = mode_sup_pkg::MODE_RESET;
		endcase
		n = 0;
		while (mode !== expMode && n < lim) begin
			tick(1);
			n++;
		end
		chk("mode", expMode, mode);
	endtask : step

	task automatic waitIrq(input logic v, input int lim);
		n = 0;
		while (irqB !== v && n < lim) begin
			tick(1);
			n++;
		end
		chk("irqB", v, irqB);
	endtask : waitIrq

	task automatic sendMode(input logic [1:0] sel);
		@(posedge clk);
		modeWrite      <= 1'b1;
		modeSelectBits <= sel;
		@(posedge clk);
		modeWrite <= 1'b0;
		#1;
	endtask : sendMode

	// Normal entry, then wait into the open half of the watchdog window
	task automatic toNormal();
		sendMode(mode_sup_pkg::MODE_SEL_NORMAL);
		step(1, 1);
		tick(WP / 2 + 5);
	endtask : toNormal

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{modeWrite, linStatusRead, hsCtrl, pwmEnable, directPwmInput, regulatorBelowThreshold} = '0;
		{regulatorOvertemp, linOvercurrent, wakeInputOne, wakeInputTwo, linWake, pullLow} = '0;
		{chipSelectB, watchdogConfigPin, rst_b} = 3'b110;
		{modeSelectBits, lsCtrl, linErr, ackDelay, interruptMaskReg} = '0;
		lpCfg   = '0;
		faultIn = '0;
		expMode = mode_sup_pkg::MODE_RESET;
		tick(5);
		chk("resetOe", 1, resetOe);
		chk("irqB", 1, irqB);
		rst_b <= 1'b1;
		step(0, RH + 8);
		chk("holdLen", 1, n >= RH - 2);
		chk("nreqOut", 1, resetIn & linRxOnly & regulatorOn);
		step(5, NT + 8);
		chk("timeoutLen", 1, n >= NT - 4);
		step(0, RH + 8);
		sendMode(mode_sup_pkg::MODE_SEL_NORMAL);
		step(1, 1);
		sendMode(mode_sup_pkg::MODE_SEL_NORMAL);
		step(5, 3);
		step(0, RH + 8);
		toNormal();
		sendMode(mode_sup_pkg::MODE_SEL_NORMAL);
		step(1, 1);
		for (i = 0; i < 4; i++) begin
			r = xs();
			hsCtrl         <= r[0];
			lsCtrl         <= r[2:1];
			pwmEnable      <= r[3];
			directPwmInput <= r[4];
			tick(6);
			chk("hs", r[0] & (!r[3] | r[4]), highSideSwitch);
			chk("ls", r[2:1] & {2{!r[3] | r[4]}}, lowSideSwitches);
		end
		step(5, WP + 8);
		chk("wdLate", 1, n >= WP - 40);
		chk("swOff", 0, {highSideSwitch, lowSideSwitches});
		step(0, RH + 8);
		toNormal();
		lpCfg.wakeOneEn <= 1'b1;
		sendMode(SEL_STOP);
		step(2, 1);
		chk("limited", 1, regulatorLimited);
		wakeInputOne <= 1'b1;
		step(4, 12);
		waitIrq(1'b0, 4);
		chk("srcOne", 4'h1, interruptSourceReg);
		ackDelay <= 4'h1;
		waitIrq(1'b1, 8);
		ackDelay <= 4'h0;
		chk("srcClr", 4'h0, interruptSourceReg);
		toNormal();
		sendMode(SEL_STOP);
		step(2, 1);
		chipSelectB <= 1'b0;
		tick(2);
		chipSelectB <= 1'b1;
		step(4, 12);
		tick(3);
		chk("csNoIrq", {1'b1, 4'h0}, {irqB, interruptSourceReg});
		toNormal();
		sendMode(SEL_STOP);
		step(2, 1);
		pullLow <= 1'b1;
		step(5, 20);
		tick(RH + 10);
		chk("extHeld", {expMode, 1'b1}, {mode, irqB});
		pullLow <= 1'b0;
		step(0, 8);
		toNormal();
		hsCtrl    <= 1'b0;
		pwmEnable <= 1'b0;
		lpCfg     <= 4'h8;
		sendMode(SEL_SLEEP);
		step(3, 1);
		chk("sleepOut", 2'b01, {regulatorOn, lowPowerOscOn});
		n = 0;
		while (highSideSwitch !== 1'b1 && n < CP + 10) begin
			tick(1);
			n++;
		end
		chk("cyclicHs", 1, highSideSwitch);
		linWake <= 1'b1;
		step(4, 12);
		linWake <= 1'b0;
		chk("wakeLin", 2'b01, {batteryFailFlag, interruptSourceReg.lin});
		// Grounded watchdog pin is only noticed in Reset mode, so set it now
		watchdogConfigPin       <= 1'b0;
		lpCfg                   <= 4'h0;
		ackDelay                <= 4'h1;
		regulatorBelowThreshold <= 1'b1;
		tick(RH + 20);
		chk("regLow", {expMode, 1'b1}, {mode, resetOe});
		regulatorBelowThreshold <= 1'b0;
		step(0, RH + 8);
		chk("stretch", 2'b11, {n >= RH - 2, watchdogOff});
		ackDelay <= 4'h0;
		for (i = 0; i < 6; i++) begin
			interruptMaskReg <= 6'h01 << i;
			faultIn          <= mode_sup_pkg::fault_t'(6'h01 << i);
			tick(2);
			faultIn <= '0;
			waitIrq(1'b0, 6);
			tick(6);
			chk("irqHold", {1'b0, 6'h01 << i}, {irqB, faultStatus});
			ackDelay <= 4'h3;
			waitIrq(1'b1, 10);
			ackDelay <= 4'h0;
		end
		interruptMaskReg <= 6'h3E;
		faultIn          <= mode_sup_pkg::fault_t'(6'h01);
		tick(8);
		chk("masked", 1, irqB);
		faultIn          <= '0;
		interruptMaskReg <= 6'h00;
		for (i = 0; i < 4; i++) begin
			linErr         <= (i < 3) ? 3'h1 << i : 3'h0;
			linOvercurrent <= (i == 3);
			tick(5);
			chk("linFault", {i == 3, i == 3}, {linDriverEn, linOvercurrentFlag});
			{linErr, linOvercurrent} <= '0;
			tick(5);
			chk("linKept", {i == 3, i == 3}, {linDriverEn, linOvercurrentFlag});
			linStatusRead <= 1'b1;
			tick(1);
			linStatusRead <= 1'b0;
			tick(4);
			chk("linAck", 2'b10, {linDriverEn, linOvercurrentFlag});
		end
		regulatorOvertemp <= 1'b1;
		tick(5);
		chk("otFlag", 2'h2, {regulatorOvertempFlag, regulatorOn});
		final_report();
	end
endmodule : operating_mode_supervisor_tb_top
